// >>> inc/cal_sched_map.vh
// Purpose: Constants for the head thermal recalibration scheduler.
// Assumes: 50 MHz system clock, millisecond base tick.
// Notes: Times are kept in their own unit; cycle counts derive from them.
//
// Contract
// [RL1] Variant one: never start during active command
// [RL2] Variant one: command waits for current head
// [RL3] Variant one: queued command runs, then next head
// [RL4] Variant one: cycle ends all heads or 10 min
// [RL5] Variant one: power-up cycle, another 1 min later
// [RL6] Variant one: new cycle every 10 minutes
// [RL7] Rezero restarts the calibration interval timer
// [RL8] Variant two: all heads after power-up/reset/rezero
// [RL9] Variant two: 300 s guard delay after full calibration
// [RL10] Variant two: first interval (600-300)/(2H) seconds
// [RL11] After one pass, steady interval 600/(2H)
// [RL12] Due calibration seeks 25-50 ms idle gap
// [RL13] Still pending after interval: force at boundary
// [RL14] Retry calibration failing head only; zero count suppresses
// [RL15] Head count equals data heads, at most 21
// [RL16] Timing from prescaled tick; static variant select
`ifndef CAL_SCHED_MAP_VH
`define CAL_SCHED_MAP_VH

`define CLK_HZ 50000000
`define MS_PER_S 1000
`define TICK_MS 1
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define MAX_PERIOD_S 600
`define GUARD_S 300
`define V1_CYCLE_S 600
`define V1_POST_INIT_S 60
`define IDLE_MIN_MS 25
`define IDLE_MAX_MS 50
`define MAX_HEADS 21
`define HEAD_W 5
`define MS_W 20
`define ZERO_MS 20'h0_0000
`define ZERO_HEAD 5'h00
`define ONE_HEAD 5'h01
`define HEAD_CAP 5'h15

`endif

// >>> hdl/tick_divider.v
// Purpose: One-cycle enable pulse every TICK_CYCLES system clocks.
// Assumes: Single clock domain.
// Notes: Divider restarts on reset only.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter integer TICK_CYCLES = 50000
) (
  input wire clk_in,
  input wire rst_n_in,
  output reg tick_out
);
  reg [31:0] cnt_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_q == TICK_CYCLES - 1) begin
      cnt_q <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end
endmodule // tick_divider
`default_nettype wire

// >>> hdl/head_thermal_cal_scheduler.v
// Purpose: Schedules head thermal recalibration against host command execution.
// Assumes: Command engine signals are on CLK_IN; bus reset is already synchronous.
// Notes: One calibration step per CAL_START_OUT pulse, finished by CAL_DONE_IN.
`timescale 1ns/1ps
`default_nettype none
`include "cal_sched_map.vh"
module head_thermal_cal_scheduler #(
  parameter integer TICK_CYCLES = `TICK_CYCLES,
  parameter integer V1_CYCLE_MS = `V1_CYCLE_S * `MS_PER_S,
  parameter integer V1_POST_INIT_MS = `V1_POST_INIT_S * `MS_PER_S,
  parameter integer GUARD_MS = `GUARD_S * `MS_PER_S,
  parameter integer MAX_PERIOD_MS = `MAX_PERIOD_S * `MS_PER_S,
  parameter integer IDLE_MIN_MS = `IDLE_MIN_MS
) (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire VARIANT_SEL_IN,
  input wire [`HEAD_W-1:0] HEAD_COUNT_IN,
  input wire BUS_RESET_IN,
  input wire INIT_DONE_IN,
  input wire CMD_PENDING_IN,
  input wire CMD_ACTIVE_IN,
  input wire CMD_BOUNDARY_IN,
  input wire REZERO_IN,
  input wire RETRY_CAL_REQ_IN,
  input wire [`HEAD_W-1:0] RETRY_HEAD_IN,
  input wire RETRY_COUNT_ZERO_IN,
  input wire CAL_DONE_IN,
  output wire CMD_ALLOW_OUT,
  output reg CAL_START_OUT,
  output reg [`HEAD_W-1:0] CAL_HEAD_OUT,
  output wire CAL_BUSY_OUT,
  output reg FULL_CAL_DONE_OUT
);
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_CAL = 6'b000010;
  localparam [5:0] S_YIELD = 6'b000100;
  localparam [5:0] S_WAIT = 6'b001000;
  localparam [5:0] S_GUARD = 6'b010000;
  localparam [5:0] S_RUN = 6'b100000;

  // ------------------------------------------------------------
  // Timebase and head count
  // ------------------------------------------------------------
  wire tick;
  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick ( // RL16
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_out(tick)
  );

  // Clamp to the physical maximum; zero heads would divide by zero
  wire [`HEAD_W-1:0] heads = (HEAD_COUNT_IN > `MAX_HEADS) ? `HEAD_CAP : // RL15
                              ((HEAD_COUNT_IN == `ZERO_HEAD) ? `ONE_HEAD : HEAD_COUNT_IN);
  wire [31:0] n1_ms = (MAX_PERIOD_MS - GUARD_MS) / (2 * heads); // RL10
  wire [31:0] n2_ms = MAX_PERIOD_MS / (2 * heads); // RL11

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg [5:0] state_q;
  reg [31:0] timer_q;
  reg [31:0] cycle_q;
  reg [`HEAD_W-1:0] head_q;
  reg [`MS_W-1:0] idle_q;
  reg full_q;
  reg steady_q;
  reg due_q;
  reg single_q;
  reg post_init_q;
  reg init_seen_q;
  reg retry_q;
  reg [`HEAD_W-1:0] retry_head_q;

  wire v2 = VARIANT_SEL_IN; // RL16
  wire [31:0] interval = steady_q ? n2_ms : n1_ms;
  wire cal_phase = (state_q == S_CAL) || (state_q == S_WAIT);
  wire init_edge = INIT_DONE_IN && !init_seen_q;
  wire restart = BUS_RESET_IN || REZERO_IN;
  wire idle_ok = (idle_q >= IDLE_MIN_MS[`MS_W-1:0]); // RL12
  wire retry_new = RETRY_CAL_REQ_IN && !RETRY_COUNT_ZERO_IN; // RL14
  // A start decided at this edge, other than an idle-gap start in S_RUN, must not race a command launch at the same edge
  wire cal_soon = (state_q == S_IDLE && full_q) ||
                  ((state_q == S_IDLE || state_q == S_RUN) && retry_q) ||
                  (state_q == S_RUN && due_q && timer_q >= interval && CMD_BOUNDARY_IN); // RL1 RL8 RL13

  // Host commands are held whenever a head is being calibrated
  assign CMD_ALLOW_OUT = !cal_phase && !cal_soon && !(state_q == S_YIELD && CAL_START_OUT); // RL2
  assign CAL_BUSY_OUT = cal_phase;

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= S_IDLE;
      timer_q <= 32'h0000_0000;
      cycle_q <= 32'h0000_0000;
      head_q <= `ZERO_HEAD;
      idle_q <= `ZERO_MS;
      full_q <= 1'b1;
      steady_q <= 1'b0;
      due_q <= 1'b0;
      single_q <= 1'b0;
      post_init_q <= 1'b0;
      init_seen_q <= 1'b0;
      retry_q <= 1'b0;
      retry_head_q <= `ZERO_HEAD;
      CAL_START_OUT <= 1'b0;
      CAL_HEAD_OUT <= `ZERO_HEAD;
      FULL_CAL_DONE_OUT <= 1'b0;
    end else begin
      CAL_START_OUT <= 1'b0;
      // Idle-gap counter; saturates at the upper bound
      if (CMD_ACTIVE_IN || CMD_PENDING_IN)
        idle_q <= `ZERO_MS;
      else if (tick && idle_q < `IDLE_MAX_MS)
        idle_q <= idle_q + 20'h0_0001; // RL12
      // Retry calibration request, latched until serviced
      if (retry_new) begin // RL14
        retry_q <= 1'b1;
        retry_head_q <= RETRY_HEAD_IN;
      end
      if (tick)
        timer_q <= timer_q + 32'h0000_0001;
      if (tick && cal_phase)
        cycle_q <= cycle_q + 32'h0000_0001;

      if (restart) begin
        // Rezero restarts the interval timer; variant two recalibrates all heads
        timer_q <= 32'h0000_0000; // RL7
        due_q <= 1'b0;
        if (v2) begin
          full_q <= 1'b1; // RL8
          state_q <= S_IDLE;
        end
      end else begin
        case (state_q)
          S_IDLE: begin
            if (full_q) begin
              // Full pass: also the variant-one power-up cycle
              head_q <= `ZERO_HEAD;
              single_q <= 1'b0;
              cycle_q <= 32'h0000_0000;
              if (!CMD_ACTIVE_IN) begin // RL1
                CAL_START_OUT <= 1'b1;
                CAL_HEAD_OUT <= `ZERO_HEAD;
                state_q <= S_CAL;
              end
            end else if (retry_q && !CMD_ACTIVE_IN) begin
              // A request in the same cycle as the service is kept
              retry_q <= retry_new;
              single_q <= 1'b1;
              CAL_START_OUT <= 1'b1;
              CAL_HEAD_OUT <= retry_head_q; // RL14
              state_q <= S_CAL;
            end else if (!v2) begin
              if (init_edge) begin
                // Init rise is held until the power-up pass has finished
                init_seen_q <= 1'b1;
                timer_q <= 32'h0000_0000;
                post_init_q <= 1'b1;
              end else if (timer_q >= (post_init_q ? V1_POST_INIT_MS : V1_CYCLE_MS)) begin // RL5 RL6
                post_init_q <= 1'b0;
                timer_q <= 32'h0000_0000;
                full_q <= 1'b1;
              end
            end else begin
              state_q <= S_GUARD;
            end
          end
          S_CAL: begin
            if (CAL_DONE_IN) begin
              if (single_q) begin
                single_q <= 1'b0;
                state_q <= v2 ? S_RUN : S_IDLE;
              end else if (head_q == heads - 5'h01 ||
                           (!v2 && cycle_q >= V1_CYCLE_MS)) begin // RL4
                full_q <= 1'b0;
                timer_q <= 32'h0000_0000;
                steady_q <= 1'b0;
                FULL_CAL_DONE_OUT <= 1'b1;
                state_q <= v2 ? S_GUARD : S_IDLE; // RL9
              end else begin
                head_q <= head_q + 5'h01;
                // Variant one lets one queued command run between heads
                state_q <= (!v2 && CMD_PENDING_IN) ? S_YIELD : S_WAIT; // RL3
              end
            end
          end
          S_YIELD: begin
            // Wait for the queued command to start and then complete
            if (CMD_ACTIVE_IN)
              state_q <= S_WAIT;
            else if (!CMD_PENDING_IN && !CAL_START_OUT) begin
              CAL_START_OUT <= 1'b1;
              CAL_HEAD_OUT <= head_q;
              state_q <= S_CAL;
            end
          end
          S_WAIT: begin
            if (!CMD_ACTIVE_IN) begin // RL1 RL3
              CAL_START_OUT <= 1'b1;
              CAL_HEAD_OUT <= head_q;
              state_q <= S_CAL;
            end
          end
          S_GUARD: begin
            if (timer_q >= GUARD_MS) begin // RL9
              timer_q <= 32'h0000_0000;
              head_q <= `ZERO_HEAD;
              state_q <= S_RUN;
            end
          end
          S_RUN: begin
            if (retry_q && !CMD_ACTIVE_IN) begin
              // Retry cal of the failing head; the interval timer keeps running
              retry_q <= retry_new;
              single_q <= 1'b1;
              CAL_START_OUT <= 1'b1;
              CAL_HEAD_OUT <= retry_head_q; // RL14
              state_q <= S_CAL;
            end else if (!due_q && timer_q >= interval) begin // RL10 RL11
              due_q <= 1'b1;
              timer_q <= 32'h0000_0000;
            end else if (due_q && !CMD_ACTIVE_IN &&
                         (idle_ok || (timer_q >= interval && CMD_BOUNDARY_IN))) begin // RL12 RL13
              due_q <= 1'b0;
              timer_q <= 32'h0000_0000; // RL13
              single_q <= 1'b1;
              CAL_START_OUT <= 1'b1;
              CAL_HEAD_OUT <= head_q;
              if (head_q == heads - 5'h01) begin
                head_q <= `ZERO_HEAD;
                steady_q <= 1'b1; // RL11
              end else
                head_q <= head_q + 5'h01;
              state_q <= S_CAL;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // head_thermal_cal_scheduler
`default_nettype wire

// >>> dv/cal_sched_sva.sv
// Purpose: Port checks for the recal scheduler.
// Assumes: HEAD_COUNT_IN static, 1..21.
// Notes: Guard is only tracked from the first full pass.
`timescale 1ns/1ps
`default_nettype none
`include "cal_sched_map.vh"
module cal_sched_sva #(parameter int TICK_CYCLES = 10, parameter int GUARD_MS = 100) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic VARIANT_SEL_IN,
  input wire logic [`HEAD_W-1:0] HEAD_COUNT_IN,
  input wire logic BUS_RESET_IN,
  input wire logic CMD_PENDING_IN,
  input wire logic CMD_ACTIVE_IN,
  input wire logic CAL_DONE_IN,
  input wire logic CMD_ALLOW_OUT,
  input wire logic CAL_START_OUT,
  input wire logic [`HEAD_W-1:0] CAL_HEAD_OUT,
  input wire logic FULL_CAL_DONE_OUT
);
  localparam int LIM = (GUARD_MS - 1) * TICK_CYCLES;
  logic [15:0] g_q;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) g_q <= 16'hffff;
    else if ($rose(FULL_CAL_DONE_OUT)) g_q <= 16'h0000;
    else if (g_q != 16'hffff) g_q <= g_q + 16'h0001;
  end
  sequence s_full; VARIANT_SEL_IN && BUS_RESET_IN && !CMD_ACTIVE_IN; endsequence
  sequence s_yield; !VARIANT_SEL_IN && CAL_DONE_IN && CMD_PENDING_IN; endsequence
  property p_idle; CAL_START_OUT |-> !$past(CMD_ACTIVE_IN); endproperty
  a_idle: assert property (p_idle) else $error("start in command");
  property p_pulse; CAL_START_OUT |=> !CAL_START_OUT; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_hold; CAL_START_OUT |-> !CMD_ALLOW_OUT ##1 !CMD_ALLOW_OUT; endproperty
  a_hold: assert property (p_hold) else $error("command let in");
  property p_yield; s_yield |=> CMD_ALLOW_OUT; endproperty
  a_yield: assert property (p_yield) else $error("no yield");
  property p_head; CAL_START_OUT |-> CAL_HEAD_OUT < HEAD_COUNT_IN && CAL_HEAD_OUT <= 5'h14; endproperty
  a_head: assert property (p_head) else $error("bad head");
  property p_full; s_full |=> !CMD_ALLOW_OUT [*2]; endproperty
  a_full: assert property (p_full) else $error("command before recal");
  property p_stick; FULL_CAL_DONE_OUT |=> FULL_CAL_DONE_OUT; endproperty
  a_stick: assert property (p_stick) else $error("pass flag lost");
  property p_guard; VARIANT_SEL_IN && CAL_START_OUT |-> g_q >= LIM; endproperty
  a_guard: assert property (p_guard) else $error("start in guard");
endmodule // cal_sched_sva
bind head_thermal_cal_scheduler cal_sched_sva #(.TICK_CYCLES(TICK_CYCLES), .GUARD_MS(GUARD_MS)) u_sva (
  .CLK_IN, .RST_N_IN, .VARIANT_SEL_IN, .HEAD_COUNT_IN, .BUS_RESET_IN, .CMD_PENDING_IN, .CMD_ACTIVE_IN,
  .CAL_DONE_IN, .CMD_ALLOW_OUT, .CAL_START_OUT, .CAL_HEAD_OUT, .FULL_CAL_DONE_OUT);
`default_nettype wire

// >>> dv/cmd_engine_model.sv
// Purpose: Command engine facing the scheduler.
// Assumes: At most one queued host command.
// Notes: Cal latency is set per scenario, prompt or slow.
`timescale 1ns/1ps
`default_nettype none
module cmd_engine_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cal_start_in,
  input wire logic cmd_allow_in,
  input wire logic cmd_req_in,
  input wire logic [7:0] lat_in,
  output logic cal_done_out,
  output logic cmd_pending_out,
  output wire logic cmd_active_out
);
  int cal_q;
  int cmd_q;
  assign cmd_active_out = (cmd_q != 0);
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_q <= 0;
      cmd_q <= 0;
      cal_done_out <= 1'h0;
      cmd_pending_out <= 1'h0;
    end else begin
      cal_done_out <= (cal_q == 1);
      if (cal_start_in) cal_q <= int'(lat_in);
      else if (cal_q != 0) cal_q <= cal_q - 1;
      if (cmd_req_in) cmd_pending_out <= 1'h1;
      // Launch only on grant, as a real engine would
      if (cmd_q != 0) begin
        cmd_q <= cmd_q - 1;
      end else if (cmd_pending_out && cmd_allow_in) begin
        cmd_pending_out <= 1'h0;
        cmd_q <= 30;
      end
    end
  end
endmodule // cmd_engine_model
`default_nettype wire

// >>> dv/tb.sv
// Purpose: Self-checking bench for the scheduler.
// Assumes: Shortened timing, three heads.
// Notes: Gap windows allow for tick phase and idle search.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h0, rst_n = 1'h0, vsel = 1'h1, brst = 1'h0, init = 1'h0;
  logic rez = 1'h0, rtq = 1'h0, rt0 = 1'h0, creq = 1'h0, bnd = 1'h0;
  logic [4:0] rth = 5'h02;
  logic [7:0] lat = 8'h01;
  logic cpend, cact, cdone, allow, cst, cbusy, fdone, fd_p;
  logic [4:0] chd;
  logic [4:0] hd[$];
  int st[$];
  int n_mismatch = 0, n_tests = 0, cyc = 0, fd_t = 0, ca_t = 0, ti = 0;
  initial forever #10 clk = ~clk;
  head_thermal_cal_scheduler #(.TICK_CYCLES(10), .V1_CYCLE_MS(200), .V1_POST_INIT_MS(50), .GUARD_MS(100),
    .MAX_PERIOD_MS(400), .IDLE_MIN_MS(5)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .VARIANT_SEL_IN(vsel),
    .HEAD_COUNT_IN(5'h03), .BUS_RESET_IN(brst), .INIT_DONE_IN(init), .CMD_PENDING_IN(cpend),
    .CMD_ACTIVE_IN(cact), .CMD_BOUNDARY_IN(bnd), .REZERO_IN(rez), .RETRY_CAL_REQ_IN(rtq), .RETRY_HEAD_IN(rth),
    .RETRY_COUNT_ZERO_IN(rt0), .CAL_DONE_IN(cdone), .CMD_ALLOW_OUT(allow), .CAL_START_OUT(cst),
    .CAL_HEAD_OUT(chd), .CAL_BUSY_OUT(cbusy), .FULL_CAL_DONE_OUT(fdone));
  cmd_engine_model u_eng (.clk_in(clk), .rst_n_in(rst_n), .cal_start_in(cst), .cmd_allow_in(allow),
    .cmd_req_in(creq), .lat_in(lat), .cal_done_out(cdone), .cmd_pending_out(cpend), .cmd_active_out(cact));
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cst === 1'h1) st.push_back(cyc);
    if (cst === 1'h1) hd.push_back(chd);
    if (fdone === 1'h1 && fd_p !== 1'h1) fd_t = cyc;
    fd_p = fdone;
    if (cact === 1'h1 && ca_t == 0) ca_t = cyc;
    if (cyc == 16000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(logic g);
    n_tests++;
    if (g !== 1'h1) begin
      n_mismatch++;
      $display("[ERR] %0t check failed", $time);
    end
  endtask
  task automatic wait_n(int n);
    int k;
    k = 0;
    while (st.size() < n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk(st.size() >= n);
  endtask
  task automatic pulse(int w);
    @(posedge clk);
    {creq, rtq, rez, brst} <= 4'h1 << w;
    @(posedge clk);
    {creq, rtq, rez, brst} <= 4'h0;
  endtask
  task automatic do_reset(logic v, logic [7:0] l);
    @(posedge clk);
    rst_n <= 1'h0;
    vsel <= v;
    lat <= l;
    init <= 1'h0;
    repeat (8) @(posedge clk);
    st.delete();
    hd.delete();
    ca_t = 0;
    rst_n <= 1'h1;
    init <= v;
  endtask
  task automatic t_v2;
    do_reset(1'h1, 8'h01);
    wait_n(7);
    for (int i = 0; i < 3; i++) chk(hd[i] === 5'(i));
    chk(fdone === 1'h1);
    chk(st[3] - fd_t >= 990 && st[3] - fd_t <= 1600);
    chk(st[4] - st[3] >= 490 && st[4] - st[3] <= 580);
    chk(st[6] - st[5] >= 650 && st[6] - st[5] <= 740);
  endtask
  task automatic t_retry;
    rt0 <= 1'h1;
    pulse(2);
    repeat (40) @(posedge clk);
    chk(st.size() == 7);
    rt0 <= 1'h0;
    rth <= 5'h01;
    pulse(2);
    wait_n(8);
    chk(hd[7] === 5'h01);
  endtask
  task automatic t_refull;
    int n;
    for (int w = 0; w < 2; w++) begin
      repeat (10) @(posedge clk);
      n = st.size();
      pulse(w);
      wait_n(n + 3);
      for (int j = 0; j < 3; j++) chk(hd[n + j] === 5'(j));
    end
  endtask
  task automatic t_force;
    int n;
    n = st.size();
    // Back-to-back commands leave no idle gap, so only the boundary can force it
    creq <= 1'h1;
    bnd <= 1'h1;
    wait_n(n + 1);
    chk(st[n] - st[n - 1] >= 1980 && st[n] - st[n - 1] <= 2060);
    chk(hd[n] === 5'h00);
    creq <= 1'h0;
    bnd <= 1'h0;
  endtask
  task automatic t_v1;
    do_reset(1'h0, 8'h14);
    wait_n(1);
    chk(cbusy === 1'h1 && allow === 1'h0);
    pulse(3);
    wait_n(3);
    chk(ca_t >= st[0] + 20);
    chk(ca_t < st[1]);
    init <= 1'h1;
    ti = cyc;
    wait_n(7);
    chk(st[3] - ti >= 490 && st[3] - ti <= 580);
    chk(st[6] - st[3] >= 1990 && st[6] - st[3] <= 2100);
  endtask
  initial begin
    t_v2();
    t_retry();
    t_refull();
    t_force();
    t_v1();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
